// ==== hdl/mpb_bus.sv ====
// memory and peripheral bus pin controller: static, pc card and sdram cycles
// ----------------------------------------------------------------
// Notes on behaviour
// - pins with _n suffix are asserted at logic zero
// - all other pins, buses, clocks and selects are asserted at logic one
// - four byte write enables, enable k covers data bits 8k+7:8k
// - pc card cycles reuse enable 0 as card OE and enable 1 as card WE
// - six active-low device selects, one external device each
// - 22-bit address bus; bits 25:22 leave on separate alternate-function pins
// - data bits 16:0 are sampled during cold reset as boot configuration
// - read output enable asserted while a static or pc card device drives data, not on sdram reads
// - read_not_write high for reads, low for writes
// - wait mode: cycle stretched while wait input stays asserted
// - acknowledge mode: asserted input completes the transaction
// - buffer direction pin drives transceiver direction, device on A side
// - two active-low buffer enables control external data buffers
// - row strobe asserted for sdram activate
// - column strobe asserted for sdram read or write command
// - two active-low sdram selects, separate from device selects
// - sdram write enable asserted only on sdram write commands
// - sdram clock is driven out and times every sdram command
// - sdram read data taken on rising edges of the feedback clock input
// ----------------------------------------------------------------
module mpb_bus (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire logic cfg_wait_is_ack,
  input wire logic [mpb_pkg::WAIT_W-1:0] cfg_wait_states,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire mpb_pkg::mpb_kind_e req_kind,
  input wire logic [mpb_pkg::FULL_ADDR_W-1:0] req_addr,
  input wire logic [mpb_pkg::DATA_W-1:0] req_wdata,
  input wire logic [mpb_pkg::LANES-1:0] req_be,
  input wire logic [mpb_pkg::CS_IDX_W-1:0] req_cs,
  input wire logic req_sdsel,
  // answer side
  output logic rsp_valid,
  output logic [mpb_pkg::DATA_W-1:0] rsp_rdata,
  // boot configuration
  output logic boot_config_valid,
  output logic [mpb_pkg::BOOT_W-1:0] boot_config,
  // shared data bus pin
  input wire logic [mpb_pkg::DATA_W-1:0] bus_data_in,
  output logic [mpb_pkg::DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  // memory and peripheral pins
  output logic [mpb_pkg::CS_N-1:0] device_select_n,
  output logic [mpb_pkg::ADDR_W-1:0] bus_address,
  output logic [mpb_pkg::HI_ADDR_W-1:0] bus_address_high,
  output logic read_not_write,
  output logic read_output_enable_n,
  output logic [mpb_pkg::LANES-1:0] byte_write_enable_n,
  input wire logic wait_or_ack_n,
  output logic buffer_direction_n,
  output logic [mpb_pkg::BUFFER_OUTPUT_ENABLE_N_W-1:0] buffer_output_enable_n,
  // sdram pins
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic [mpb_pkg::SDCS_N-1:0] sdram_select_n,
  output logic sdram_write_enable_n,
  output logic sdram_clock_out,
  input wire logic sdram_clock_feedback
);
  import mpb_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] data_s;
  logic wa_s;
  logic fb_s;

  // read data is two cycles stale; slow devices cover it with wait states
  mpb_sync2 #(.W(DATA_W)) u_sync_data (.clk(clk), .d(bus_data_in), .q(data_s));
  mpb_sync2 #(.W(1)) u_sync_wait (.clk(clk), .d(wait_or_ack_n), .q(wa_s));
  mpb_sync2 #(.W(1)) u_sync_fb (.clk(clk), .d(sdram_clock_feedback), .q(fb_s));

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mpb_state_s s_r;
  mpb_state_s s_nxt;
  logic tick;
  logic fb_rise;
  logic wa_done;

  // sdram pins move while the forwarded clock falls, stable at its rise
  assign tick = s_r.sdclk;
  assign fb_rise = fb_s & ~s_r.fb_prev;
  assign wa_done = cfg_wait_is_ack ? ~wa_s : wa_s;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.fb_prev = fb_s;
    s_nxt.sdclk = ~s_r.sdclk;
    if (!s_r.boot_done)
    begin
      // first cycle after release still shows the strapped levels
      s_nxt.boot_vec = data_s[BOOT_W-1:0];
      s_nxt.boot_done = 1'b1;
    end
    case (s_r.state)
      MPB_IDLE:
      begin
        if (req_valid && req_ready)
        begin
          s_nxt.kind = req_kind;
          s_nxt.write = req_write;
          s_nxt.a = req_addr;
          s_nxt.be = req_be;
          s_nxt.sdsel = req_sdsel;
          s_nxt.dout = req_wdata;
          s_nxt.hi_addr = req_addr[HI_ADDR_LSB +: HI_ADDR_W];
          if (req_kind == MPB_K_SDRAM)
          begin
            s_nxt.state = MPB_SD_ACT;
          end
          else
          begin
            s_nxt.state = MPB_ST_ADDR;
            s_nxt.cs_n = ~(CS_ONE << req_cs);
            s_nxt.addr = req_addr[ADDR_W-1:0];
            s_nxt.rw = ~req_write;
            s_nxt.boe_n = BOE_ON;
            s_nxt.bdir_n = req_write;
            s_nxt.doe = req_write;
            s_nxt.wcnt = cfg_wait_states;
          end
        end
      end
      MPB_ST_ADDR:
      begin
        s_nxt.state = MPB_ST_STRB;
        if (s_r.kind == MPB_K_PCCARD)
        begin
          s_nxt.bwe_n = s_r.write ? PCC_WE_STROBE : PCC_OE_STROBE;
        end
        else if (s_r.write)
        begin
          s_nxt.bwe_n = ~s_r.be;
        end
        if (!s_r.write)
        begin
          s_nxt.oe_n = 1'b0;
        end
      end
      MPB_ST_STRB:
      begin
        if (s_r.wcnt != 6'h00)
        begin
          s_nxt.wcnt = s_r.wcnt - 6'h01;
        end
        else if (wa_done)
        begin
          s_nxt.state = MPB_END;
          s_nxt.oe_n = 1'b1;
          s_nxt.bwe_n = BWE_IDLE;
          s_nxt.rdata = data_s;
        end
      end
      MPB_END:
      begin
        s_nxt.state = MPB_IDLE;
        s_nxt.rsp_valid = 1'b1;
        s_nxt.cs_n = CS_IDLE;
        s_nxt.sdcs_n = SDCS_IDLE;
        s_nxt.boe_n = BOE_IDLE;
        s_nxt.doe = 1'b0;
        s_nxt.rw = 1'b1;
        s_nxt.bdir_n = 1'b0;
      end
      MPB_SD_ACT:
      begin
        if (tick)
        begin
          s_nxt.state = MPB_SD_CMD;
          s_nxt.sdcs_n = ~(SDCS_ONE << s_r.sdsel);
          s_nxt.ras_n = 1'b0;
          s_nxt.addr = ADDR_W'(s_r.a[SD_ROW_MSB:SD_ROW_LSB]);
          s_nxt.rw = ~s_r.write;
        end
      end
      MPB_SD_CMD:
      begin
        if (tick)
        begin
          s_nxt.ras_n = 1'b1;
          s_nxt.cas_n = 1'b0;
          s_nxt.sdwe_n = ~s_r.write;
          s_nxt.addr = ADDR_W'(s_r.a[SD_COL_MSB:SD_COL_LSB]);
          s_nxt.doe = s_r.write;
          s_nxt.boe_n = BOE_ON;
          s_nxt.bdir_n = s_r.write;
          s_nxt.lat = CAS_LATENCY;
          s_nxt.state = s_r.write ? MPB_SD_END : MPB_SD_LAT;
        end
      end
      MPB_SD_END:
      begin
        if (tick)
        begin
          s_nxt.cas_n = 1'b1;
          s_nxt.sdwe_n = 1'b1;
          s_nxt.sdcs_n = SDCS_IDLE;
          s_nxt.state = MPB_END;
        end
      end
      MPB_SD_LAT:
      begin
        if (tick)
        begin
          s_nxt.cas_n = 1'b1;
          s_nxt.sdcs_n = SDCS_IDLE;
        end
        if (fb_rise)
        begin
          if (s_r.lat == 2'h1)
          begin
            s_nxt.rdata = data_s;
            s_nxt.state = MPB_END;
          end
          else
          begin
            s_nxt.lat = s_r.lat - 2'h1;
          end
        end
      end
      default:
      begin
        s_nxt = MPB_STATE_RST;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_r <= MPB_STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready = (s_r.state == MPB_IDLE) && s_r.boot_done;
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_rdata = s_r.rdata;
  assign boot_config_valid = s_r.boot_done;
  assign boot_config = s_r.boot_vec;
  assign bus_data_out = s_r.dout;
  assign bus_data_oe = s_r.doe;
  assign device_select_n = s_r.cs_n;
  assign bus_address = s_r.addr;
  assign bus_address_high = s_r.hi_addr;
  assign read_not_write = s_r.rw;
  assign read_output_enable_n = s_r.oe_n;
  assign byte_write_enable_n = s_r.bwe_n;
  assign buffer_direction_n = s_r.bdir_n;
  assign buffer_output_enable_n = s_r.boe_n;
  assign row_strobe_n = s_r.ras_n;
  assign column_strobe_n = s_r.cas_n;
  assign sdram_select_n = s_r.sdcs_n;
  assign sdram_write_enable_n = s_r.sdwe_n;
  assign sdram_clock_out = s_r.sdclk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  localparam int ACK_MIN = 1;
  localparam int ACK_MAX = 2;

  sequence s_activate;
    $fell(row_strobe_n);
  endsequence

  sequence s_column;
    $fell(column_strobe_n) && row_strobe_n;
  endsequence

  AST_IDLE_PINS: assert property ((s_r.state == MPB_IDLE) |-> (device_select_n == CS_IDLE)
    && read_output_enable_n && (byte_write_enable_n == BWE_IDLE) && row_strobe_n && !bus_data_oe)
    else $error("bus pins not idle in idle state");

  AST_RW_HIGH_IDLE: assert property ((s_r.state == MPB_IDLE) |-> read_not_write)
    else $error("direction not read while idle");

  AST_BYTE_LANES: assert property ((s_r.state == MPB_ST_STRB) && (s_r.kind == MPB_K_STATIC)
    && s_r.write |-> (byte_write_enable_n == ~s_r.be))
    else $error("byte write enables do not match lanes");

  AST_PCC_STROBE: assert property ((s_r.state == MPB_ST_STRB) && (s_r.kind == MPB_K_PCCARD)
    |-> (byte_write_enable_n == (s_r.write ? PCC_WE_STROBE : PCC_OE_STROBE)))
    else $error("pc card strobe lane wrong");

  AST_ONE_SELECT: assert property ($onehot0(~device_select_n) && $onehot0(~sdram_select_n))
    else $error("more than one select asserted");

  AST_OE_ONLY_READ: assert property (!read_output_enable_n |-> read_not_write && !bus_data_oe)
    else $error("output enable during write or while driving");

  AST_DRIVE_WRITE: assert property (bus_data_oe |-> !read_not_write && !buffer_direction_n
    ^ 1'b1)
    else $error("driving data without write direction");

  AST_WAIT_HOLDS: assert property ((s_r.state == MPB_ST_STRB) && (s_r.wcnt == 6'h00)
    && !cfg_wait_is_ack && !wa_s |=> (s_r.state == MPB_ST_STRB) && !read_output_enable_n ^ s_r.write)
    else $error("cycle ended while wait asserted");

  AST_ACK_ENDS: assert property ((s_r.state == MPB_ST_STRB) && (s_r.wcnt == 6'h00)
    && cfg_wait_is_ack && !wa_s |-> ##[ACK_MIN:ACK_MAX] rsp_valid)
    else $error("acknowledge did not finish the transaction");

  AST_BUF_ENABLE: assert property ((s_r.state == MPB_ST_STRB) |-> (buffer_output_enable_n == BOE_ON))
    else $error("buffers not enabled during strobe");

  AST_ACT_THEN_COL: assert property (s_activate |-> ##2 s_column)
    else $error("column strobe not two cycles after activate");

  AST_SD_SEL: assert property (!row_strobe_n |-> $onehot(~sdram_select_n)
    && (device_select_n == CS_IDLE))
    else $error("sdram select wrong during activate");

  AST_SD_WE: assert property (!sdram_write_enable_n |-> !column_strobe_n && bus_data_oe)
    else $error("sdram write enable outside write command");

  // the first edge after release still shows the reset level, so no toggle is owed there
  AST_SDCLK_TOGGLE: assert property ($past(resetn) |-> sdram_clock_out != $past(sdram_clock_out))
    else $error("sdram clock stopped");

  AST_CMD_ON_FALL: assert property ($changed(row_strobe_n) || $changed(column_strobe_n)
    |-> !sdram_clock_out)
    else $error("sdram command moved at clock rise");

  AST_DIR_MATCH: assert property (!buffer_output_enable_n[0] |-> (buffer_direction_n == ~read_not_write))
    else $error("buffer direction disagrees with transfer");

endmodule // mpb_bus

// ==== hdl/mpb_pkg.sv ====
// shared widths, encodings, reset values and state layout of the memory and peripheral bus pins
package mpb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int FULL_ADDR_W = 26;
  localparam int HI_ADDR_W = 4;
  localparam int HI_ADDR_LSB = 22;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int CS_N = 6;
  localparam int CS_IDX_W = 3;
  localparam int SDCS_N = 2;
  localparam int BUFFER_OUTPUT_ENABLE_N_W = 2;
  localparam int BOOT_W = 17;
  localparam int WAIT_W = 6;
  localparam int LAT_W = 2;

  // ----------------------------------------------------------------
  // sdram address split (row first, then column)
  // ----------------------------------------------------------------
  localparam int SD_ROW_LSB = 12;
  localparam int SD_ROW_MSB = 25;
  localparam int SD_COL_LSB = 2;
  localparam int SD_COL_MSB = 11;
  localparam logic [LAT_W-1:0] CAS_LATENCY = 2'h2;

  // ----------------------------------------------------------------
  // pin values
  // ----------------------------------------------------------------
  localparam logic [LANES-1:0] BWE_IDLE = 4'hF;
  localparam logic [LANES-1:0] PCC_OE_STROBE = 4'hE;
  localparam logic [LANES-1:0] PCC_WE_STROBE = 4'hD;
  localparam logic [CS_N-1:0] CS_IDLE = 6'h3F;
  localparam logic [CS_N-1:0] CS_ONE = 6'h01;
  localparam logic [SDCS_N-1:0] SDCS_IDLE = 2'h3;
  localparam logic [SDCS_N-1:0] SDCS_ONE = 2'h1;
  localparam logic [BUFFER_OUTPUT_ENABLE_N_W-1:0] BOE_IDLE = 2'h3;
  localparam logic [BUFFER_OUTPUT_ENABLE_N_W-1:0] BOE_ON = 2'h0;

  // ----------------------------------------------------------------
  // kinds and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MPB_K_STATIC = 2'b00,
    MPB_K_PCCARD = 2'b01,
    MPB_K_SDRAM = 2'b10
  } mpb_kind_e;

  typedef enum logic [2:0]
  {
    MPB_IDLE = 3'b000,
    MPB_ST_ADDR = 3'b001,
    MPB_ST_STRB = 3'b010,
    MPB_END = 3'b011,
    MPB_SD_ACT = 3'b100,
    MPB_SD_CMD = 3'b101,
    MPB_SD_END = 3'b110,
    MPB_SD_LAT = 3'b111
  } mpb_state_e;

  typedef struct packed
  {
    mpb_state_e state;
    mpb_kind_e kind;
    logic write;
    logic [FULL_ADDR_W-1:0] a;
    logic [LANES-1:0] be;
    logic sdsel;
    logic [WAIT_W-1:0] wcnt;
    logic [LAT_W-1:0] lat;
    logic sdclk;
    logic fb_prev;
    logic boot_done;
    logic [BOOT_W-1:0] boot_vec;
    logic [DATA_W-1:0] rdata;
    logic rsp_valid;
    logic [CS_N-1:0] cs_n;
    logic [ADDR_W-1:0] addr;
    logic [HI_ADDR_W-1:0] hi_addr;
    logic rw;
    logic oe_n;
    logic [LANES-1:0] bwe_n;
    logic bdir_n;
    logic [BUFFER_OUTPUT_ENABLE_N_W-1:0] boe_n;
    logic ras_n;
    logic cas_n;
    logic [SDCS_N-1:0] sdcs_n;
    logic sdwe_n;
    logic [DATA_W-1:0] dout;
    logic doe;
  } mpb_state_s;

  localparam mpb_state_s MPB_STATE_RST = '{
    state: MPB_IDLE, kind: MPB_K_STATIC, write: 1'b0, a: 26'h0000000, be: 4'h0, sdsel: 1'b0,
    wcnt: 6'h00, lat: 2'h0, sdclk: 1'b0, fb_prev: 1'b0, boot_done: 1'b0, boot_vec: 17'h00000,
    rdata: 32'h00000000, rsp_valid: 1'b0, cs_n: CS_IDLE, addr: 22'h000000, hi_addr: 4'h0,
    rw: 1'b1, oe_n: 1'b1, bwe_n: BWE_IDLE, bdir_n: 1'b0, boe_n: BOE_IDLE, ras_n: 1'b1,
    cas_n: 1'b1, sdcs_n: SDCS_IDLE, sdwe_n: 1'b1, dout: 32'h00000000, doe: 1'b0};

endpackage

// ==== hdl/mpb_sync2.sv ====
// two-flop synchroniser for inputs arriving from outside the clock domain
module mpb_sync2 #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // asynchronous input and its synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q <= meta_r;
  end

endmodule // mpb_sync2

// ==== tb/mpb_mem_model.sv ====
// behavioural model of the static, pc card and sdram parts hanging on the bus pins
module mpb_mem_model (
  // clock
  input wire logic clk,
  // boot straps
  input wire logic straps_on,
  input wire logic [mpb_pkg::BOOT_W-1:0] strap,
  // pins watched
  input wire logic [mpb_pkg::CS_N-1:0] device_select_n,
  input wire logic [mpb_pkg::ADDR_W-1:0] bus_address,
  input wire logic read_output_enable_n,
  input wire logic [mpb_pkg::LANES-1:0] byte_write_enable_n,
  input wire logic [mpb_pkg::DATA_W-1:0] bus_data_out,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic [mpb_pkg::SDCS_N-1:0] sdram_select_n,
  input wire logic sdram_write_enable_n,
  input wire logic sdram_clock_out,
  // pins driven back
  output logic [mpb_pkg::DATA_W-1:0] bus_data_in,
  output logic sdram_clock_feedback
);
  timeunit 1ns;
  timeprecision 1ns;
  import mpb_pkg::*;

  logic [DATA_W-1:0] smem [0:63];
  logic [DATA_W-1:0] sdmem [logic [23:0]];
  logic [DATA_W-1:0] drv_q;
  logic [13:0] row_q;
  logic [23:0] sd_key;
  int sd_cnt;

  initial
  begin
    for (int i = 0; i < 64; i++)
      smem[i] = 32'h00000000;
    drv_q = 32'h00000000;
    sd_cnt = 0;
  end

  // ----------------
  // pins back
  // ----------------
  // straps while straps_on holds, three cycles past reset release; a released bus toggles so stale data never looks valid
  assign bus_data_in = straps_on ? {15'h0000, strap} : drv_q;
  assign #3 sdram_clock_feedback = sdram_clock_out;

  // ----------------
  // memories
  // ----------------
  // sdram commands taken where the forwarded clock is about to rise
  always @(posedge clk)
  begin
    for (int k = 0; k < LANES; k++)
      if (!byte_write_enable_n[k] && device_select_n != CS_IDLE && read_output_enable_n)
        smem[bus_address[7:2]][8*k +: 8] <= bus_data_out[8*k +: 8];
    if (!sdram_clock_out && sdram_select_n != SDCS_IDLE && !row_strobe_n && column_strobe_n)
      row_q <= bus_address[13:0];
    if (!sdram_clock_out && sdram_select_n != SDCS_IDLE && row_strobe_n && !column_strobe_n)
    begin
      sd_key = {row_q, bus_address[9:0]};
      if (!sdram_write_enable_n)
        sdmem[sd_key] = bus_data_out;
      else
        sd_cnt = 8;
    end
    if (!read_output_enable_n && device_select_n != CS_IDLE)
      drv_q <= smem[bus_address[7:2]];
    else if (sd_cnt > 0)
    begin
      drv_q <= sdmem.exists(sd_key) ? sdmem[sd_key] : 32'h00000000;
      sd_cnt--;
    end
    else
      drv_q <= ~drv_q;
  end
endmodule // mpb_mem_model

// ==== tb/tb_memory_peripheral_bus_pins.sv ====
// self-checking bench for the memory and peripheral bus pin controller
module tb_memory_peripheral_bus_pins;
  timeunit 1ns;
  timeprecision 1ns;
  import mpb_pkg::*;

  localparam logic [BOOT_W-1:0] STRAP = 17'h1A5C3;
  localparam logic [FULL_ADDR_W-1:0] ADDR_A = 26'h2C00014;
  localparam logic [DATA_W-1:0] WD = 32'hC3A596E1;

  logic clk, resetn, cfg_wait_is_ack, req_valid, req_ready, req_write, req_sdsel, rsp_valid;
  logic [WAIT_W-1:0] cfg_wait_states;
  mpb_kind_e req_kind;
  logic [FULL_ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, bus_data_in, bus_data_out;
  logic [LANES-1:0] req_be, byte_write_enable_n, and_bwe, bus_address_high;
  logic [CS_IDX_W-1:0] req_cs;
  logic boot_config_valid, bus_data_oe, read_not_write, read_output_enable_n, wait_or_ack_n;
  logic [BOOT_W-1:0] boot_config;
  logic [CS_N-1:0] device_select_n, and_cs;
  logic [ADDR_W-1:0] bus_address, addr_seen;
  logic buffer_direction_n, row_strobe_n, column_strobe_n, sdram_write_enable_n;
  logic [BUFFER_OUTPUT_ENABLE_N_W-1:0] buffer_output_enable_n, and_boe;
  logic [SDCS_N-1:0] sdram_select_n, and_sdcs;
  logic sdram_clock_out, sdram_clock_feedback, straps_on;
  logic rnw_low, oe_low, bdir_hi, ras_low, cas_low, we_low, doe_hi;
  int cyc, n_mismatch, n_compared;

  mpb_bus uut (.clk, .resetn, .cfg_wait_is_ack, .cfg_wait_states, .req_valid, .req_ready, .req_write,
    .req_kind, .req_addr, .req_wdata, .req_be, .req_cs, .req_sdsel, .rsp_valid, .rsp_rdata,
    .boot_config_valid, .boot_config, .bus_data_in, .bus_data_out, .bus_data_oe, .device_select_n,
    .bus_address, .bus_address_high, .read_not_write, .read_output_enable_n, .byte_write_enable_n,
    .wait_or_ack_n, .buffer_direction_n, .buffer_output_enable_n, .row_strobe_n, .column_strobe_n,
    .sdram_select_n, .sdram_write_enable_n, .sdram_clock_out, .sdram_clock_feedback);

  mpb_mem_model far (.clk, .straps_on, .strap(STRAP), .device_select_n, .bus_address,
    .read_output_enable_n, .byte_write_enable_n, .bus_data_out, .row_strobe_n, .column_strobe_n,
    .sdram_select_n, .sdram_write_enable_n, .sdram_clock_out, .bus_data_in, .sdram_clock_feedback);

  // ----------------
  // helpers
  // ----------------
  task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one request; pins are folded over the whole cycle, wait asserted (wait mode) or acknowledge withheld (ack mode) for hold cycles
  task automatic do_req(input mpb_kind_e kind, input logic wr, input logic [FULL_ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wd, input logic [LANES-1:0] be, input logic sds, input int hold);
    int n;
    @(negedge clk);
    req_kind = kind;
    req_write = wr;
    req_addr = addr;
    req_wdata = wd;
    req_be = be;
    req_cs = 3'h2;
    req_sdsel = sds;
    req_valid = 1'b1;
    n = 0;
    // ready only moves at a rising edge, so a high level seen here stands through the next one
    while (req_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    @(negedge clk);
    req_valid = 1'b0;
    {and_cs, and_bwe, and_boe, and_sdcs} = 14'h3FFF;
    {rnw_low, oe_low, bdir_hi, ras_low, cas_low, we_low} = 6'h00;
    doe_hi = 1'b0;
    cyc = 0;
    // pins are folded at the falling edge, where they have settled
    while (rsp_valid !== 1'b1 && cyc < 300)
    begin
      wait_or_ack_n = (cyc < hold) == cfg_wait_is_ack;
      @(negedge clk);
      cyc++;
      doe_hi |= bus_data_oe;
      and_cs &= device_select_n;
      and_bwe &= byte_write_enable_n;
      and_boe &= buffer_output_enable_n;
      and_sdcs &= sdram_select_n;
      rnw_low |= !read_not_write;
      oe_low |= !read_output_enable_n;
      bdir_hi |= buffer_direction_n;
      ras_low |= !row_strobe_n;
      cas_low |= !column_strobe_n;
      we_low |= !sdram_write_enable_n;
      if (device_select_n != CS_IDLE)
        addr_seen = bus_address;
    end
    wait_or_ack_n = 1'b1;
    check("response", 32'(rsp_valid), 32'h1);
    check("data drive", 32'(doe_hi), 32'(wr));
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset;
    logic s0;
    check("boot valid", 32'(boot_config_valid), 32'h1);
    check("boot vector", 32'(boot_config), 32'(STRAP));
    check("selects idle", 32'({device_select_n, sdram_select_n}), 32'hFF);
    check("idle levels", 32'({read_not_write, buffer_output_enable_n}), 32'h7);
    s0 = sdram_clock_out;
    @(negedge clk);
    check("sdram clock", 32'(sdram_clock_out), 32'(!s0));
  endtask

  task automatic t_static;
    do_req(MPB_K_STATIC, 1'b1, ADDR_A, WD, 4'h5, 1'b0, 0);
    check("write selects", 32'(and_cs), 32'h3B);
    check("write lanes", 32'(and_bwe), 32'hA);
    check("write direction", 32'({rnw_low, bdir_hi, oe_low}), 32'h6);
    check("buffer enables", 32'(and_boe), 32'h0);
    check("address", 32'(addr_seen), 32'(ADDR_A[21:0]));
    check("high address", 32'(bus_address_high), 32'(ADDR_A[25:22]));
    do_req(MPB_K_STATIC, 1'b0, ADDR_A, 32'h0, 4'hF, 1'b0, 0);
    check("read data", rsp_rdata, WD & 32'h00FF00FF);
    check("read pins", 32'({rnw_low, bdir_hi, oe_low, and_bwe}), 32'h1F);
  endtask

  task automatic t_wait;
    do_req(MPB_K_STATIC, 1'b0, ADDR_A, 32'h0, 4'hF, 1'b0, 20);
    check("wait stretch", 32'(cyc > 20 && cyc < 30), 32'h1);
    @(negedge clk);
    cfg_wait_is_ack = 1'b1;
    do_req(MPB_K_STATIC, 1'b0, ADDR_A, 32'h0, 4'hF, 1'b0, 20);
    check("ack hold", 32'(cyc > 20 && cyc < 30), 32'h1);
    check("ack data", rsp_rdata, WD & 32'h00FF00FF);
    @(negedge clk);
    cfg_wait_is_ack = 1'b0;
  endtask

  task automatic t_pccard;
    do_req(MPB_K_PCCARD, 1'b0, ADDR_A, 32'h0, 4'hF, 1'b0, 0);
    check("card read strobes", 32'({oe_low, and_bwe}), 32'h1E);
    check("card read data", rsp_rdata, WD & 32'h00FF00FF);
    do_req(MPB_K_PCCARD, 1'b1, ADDR_A, WD, 4'hF, 1'b0, 0);
    check("card write strobes", 32'({rnw_low, and_bwe}), 32'h1D);
  endtask

  task automatic t_sdram;
    for (int s = 0; s < 2; s++)
    begin
      do_req(MPB_K_SDRAM, 1'b1, 26'h1234568 + 26'(s * 4096), WD ^ 32'(s), 4'hF, s[0], 0);
      check("sdram write strobes", 32'({ras_low, cas_low, we_low, oe_low}), 32'hE);
      check("sdram selects", 32'({and_sdcs, and_cs}), 32'(s ? 8'h7F : 8'hBF));
      do_req(MPB_K_SDRAM, 1'b0, 26'h1234568 + 26'(s * 4096), 32'h0, 4'hF, s[0], 0);
      check("sdram read data", rsp_rdata, WD ^ 32'(s));
      check("sdram read strobes", 32'({ras_low, cas_low, we_low}), 32'h6);
    end
  endtask

  // ----------------
  // clock, watchdog, main
  // ----------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end

  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    resetn = 1'b0;
    straps_on = 1'b1;
    cfg_wait_is_ack = 1'b0;
    cfg_wait_states = 6'h04;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_kind = MPB_K_STATIC;
    req_addr = 26'h0000000;
    req_wdata = 32'h00000000;
    req_be = 4'h0;
    req_cs = 3'h0;
    req_sdsel = 1'b0;
    wait_or_ack_n = 1'b1;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    straps_on = 1'b0;
    t_reset();
    t_static();
    t_wait();
    t_pccard();
    t_sdram();
    results();
  end
endmodule // tb_memory_peripheral_bus_pins
